// ==== rtl/wwc_pkg.sv ====
// Purpose: Shared constants and carriers for the configuration decoder
// Assumes: 16-bit configuration words in the low half of a 32-bit bus word
// Notes: Byte address of a word is four times its index
package wwc_pkg;
  // Word indices; the byte address is four times the index
  localparam logic [23:0] WWC_IDX_WD_CFG = 24'h300004;
  localparam logic [23:0] WWC_IDX_NVM_CFG = 24'h300006;
  localparam logic [31:0] WWC_ADDR_WD_CFG = {6'h00, WWC_IDX_WD_CFG, 2'b00};
  localparam logic [31:0] WWC_ADDR_NVM_CFG = {6'h00, WWC_IDX_NVM_CFG, 2'b00};
  localparam logic [31:0] WWC_ADDR_STATUS = 32'h0000_0000;

  // Watchdog word fields
  localparam int WWC_CCS_LSB = 11;
  localparam int WWC_CWS_LSB = 8;
  localparam int WWC_MODE_LSB = 5;
  localparam int WWC_CPS_LSB = 0;
  localparam logic [15:0] WWC_WD_RST = 16'h3f7f;
  localparam logic [15:0] WWC_WD_MASK = 16'h3f7f;

  // Memory protection word fields
  localparam int WWC_LOWV_BIT = 13;
  localparam int WWC_SCAN_BIT = 12;
  localparam int WWC_EEP_BIT = 10;
  localparam int WWC_BOOT_BIT = 9;
  localparam int WWC_CFGP_BIT = 8;
  localparam int WWC_BLK_LSB = 0;
  localparam logic [15:0] WWC_NVM_RST = 16'h370f;
  localparam logic [15:0] WWC_NVM_MASK = 16'h370f;

  // Status word fields
  localparam int WWC_ST_LOADED = 0;
  localparam int WWC_ST_RUN = 1;
  localparam int WWC_ST_CLK_LSB = 2;
  localparam int WWC_ST_LOWV_PROG = 4;
  localparam int WWC_ST_CFG_LOCK = 5;

  // Field codes
  localparam logic [2:0] WWC_CCS_SW = 3'h7;
  localparam logic [2:0] WWC_CCS_MF = 3'h1;
  localparam logic [2:0] WWC_CCS_LF = 3'h0;
  localparam logic [2:0] WWC_CWS_OPEN_MIN = 3'h6;
  localparam logic [2:0] WWC_CWS_EIGHTHS = 3'h7;
  localparam logic [4:0] WWC_CPS_SW = 5'h1f;
  localparam logic [4:0] WWC_CPS_POR = 5'h0b;
  localparam logic [4:0] WWC_CPS_MAX = 5'h12;
  localparam logic [4:0] WWC_DIV_BASE = 5'h05;

  localparam logic [1:0] WWC_RESP_OKAY = 2'h0;
  localparam logic [1:0] WWC_RESP_SLVERR = 2'h2;
  localparam logic [1:0] WWC_RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    WWC_MODE_OFF = 2'h0,
    WWC_MODE_SW = 2'h1,
    WWC_MODE_AWAKE = 2'h2,
    WWC_MODE_ON = 2'h3
  } wwc_mode_e;

  typedef enum logic [1:0] {
    WWC_CLK_NONE = 2'h0,
    WWC_CLK_LF = 2'h1,
    WWC_CLK_MF = 2'h2,
    WWC_CLK_SW = 2'h3
  } wwc_wdclk_e;

  typedef enum logic [2:0] {
    WWC_S_HOLD = 3'h1,
    WWC_S_LOAD = 3'h2,
    WWC_S_RUN = 3'h4
  } wwc_state_e;

  typedef struct packed {
    logic run;
    wwc_wdclk_e clk_sel;
    logic [2:0] window_por;
    logic [2:0] closed_eighths;
    logic window_sw_ok;
    logic keyed_required;
    logic [4:0] period_por;
    logic [4:0] div_exp;
    logic period_sw_ok;
  } wwc_wd_out_s;

  typedef struct packed {
    logic reset_pin_is_reset;
    logic hv_prog_required;
    logic scanner_enabled;
    logic eeprom_wr_block;
    logic boot_wr_block;
    logic config_wr_block;
    logic [3:0] block_wr_block;
  } wwc_nvm_out_s;
endpackage : wwc_pkg

// ==== rtl/wwc_wd_decode.sv ====
// Purpose: Watchdog settings from the watchdog configuration word
// Assumes: Word is static; enable and sleep are same-clock levels
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
module wwc_wd_decode (
  input wire logic [15:0] i_cfg,
  input wire logic i_sw_enable,
  input wire logic i_sleep,
  output wwc_pkg::wwc_wd_out_s o_wd
);
  import wwc_pkg::*;

  wire wwc_mode_e mode = wwc_mode_e'(i_cfg[WWC_MODE_LSB +: 2]);
  wire logic [2:0] ccs = i_cfg[WWC_CCS_LSB +: 3];
  wire logic [2:0] cws = i_cfg[WWC_CWS_LSB +: 3];
  wire logic [4:0] cps = i_cfg[WWC_CPS_LSB +: 5];
  wire logic win_open = (cws >= WWC_CWS_OPEN_MIN);
  wire logic per_sw = (cps == WWC_CPS_SW);
  wire logic [4:0] per_code = per_sw ? WWC_CPS_POR : cps;
  // Codes 10011 to 11110 all collapse to the shortest divider
  wire logic [4:0] div_exp = (per_code <= WWC_CPS_MAX) ?
    5'(per_code + WWC_DIV_BASE) : WWC_DIV_BASE;
  wire logic run =
    (mode == WWC_MODE_ON) |
    ((mode == WWC_MODE_AWAKE) & ~i_sleep) |
    ((mode == WWC_MODE_SW) & i_sw_enable);
  wire wwc_wdclk_e clk_sel =
    (mode == WWC_MODE_OFF) ? WWC_CLK_NONE :
    (ccs == WWC_CCS_SW) ? WWC_CLK_SW :
    (ccs == WWC_CCS_MF) ? WWC_CLK_MF : WWC_CLK_LF;

  assign o_wd.run = run;
  assign o_wd.clk_sel = clk_sel;
  assign o_wd.window_por = cws;
  assign o_wd.closed_eighths = win_open ? 3'h0 : 3'(WWC_CWS_EIGHTHS - cws);
  assign o_wd.window_sw_ok = win_open;
  assign o_wd.keyed_required = ~win_open;
  assign o_wd.period_por = per_code;
  assign o_wd.div_exp = div_exp;
  assign o_wd.period_sw_ok = per_sw;
endmodule : wwc_wd_decode

// ==== rtl/wwc_nvm_decode.sv ====
// Purpose: Programming and write protection settings from the memory word
// Assumes: Protection bits are active low; word is static
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
module wwc_nvm_decode (
  input wire logic [15:0] i_cfg,
  input wire logic i_reset_pin_enable,
  input wire logic i_scanner_disable,
  output wwc_pkg::wwc_nvm_out_s o_nvm
);
  import wwc_pkg::*;

  wire logic lowv = i_cfg[WWC_LOWV_BIT];
  wire logic scan = i_cfg[WWC_SCAN_BIT];

  // Low-voltage mode forces the shared pin to reset duty
  assign o_nvm.reset_pin_is_reset = lowv | i_reset_pin_enable;
  assign o_nvm.hv_prog_required = ~lowv;
  assign o_nvm.scanner_enabled = scan & ~i_scanner_disable;
  assign o_nvm.eeprom_wr_block = ~i_cfg[WWC_EEP_BIT];
  assign o_nvm.boot_wr_block = ~i_cfg[WWC_BOOT_BIT];
  assign o_nvm.config_wr_block = ~i_cfg[WWC_CFGP_BIT];
  assign o_nvm.block_wr_block = ~i_cfg[WWC_BLK_LSB +: 4];
endmodule : wwc_nvm_decode

// ==== rtl/wwc_config_top.sv ====
// Purpose: Holds and decodes the watchdog and memory protection words
// Assumes: AXI4-Lite slave, one write and one read outstanding at most
// Notes: Words survive i_reset_n; only i_por_n returns them to erased state
//
// Overview of operation
// - Operating mode 00 makes the watchdog clock selector irrelevant.
// - Selector 111 gives software the clock, 001 medium osc, 000 low osc.
// - Reserved selector codes 010 to 110 fall back to the low oscillator.
// - Window 111/110 fully open, software may change; others fixed, keyed.
// - Mode 11 runs the watchdog awake and asleep, software bit ignored.
// - Mode 10 runs while awake, suspends in sleep, software bit ignored.
// - Mode 01 lets the software enable bit turn the watchdog on or off.
// - Mode 00 keeps the watchdog off whatever the software bit says.
// - Period 11111 loads runtime code 01011 and allows software changes.
// - Codes up to 10010 divide by 2^(5+code); 10011..11110 by 32; locked.
// - Writing zero to low-voltage enable is refused while so programming.
// - Low-voltage enable makes the shared pin a reset; else high voltage.
// - Scanner enable 1 gates scanner by its disable bit; 0 keeps it off.
// - Eeprom protection bit at 0 blocks data eeprom writes.
// - Boot protection bit at 0 blocks boot block writes.
// - Configuration protection bit at 0 blocks configuration word writes.
// - Each of four block protection bits at 0 blocks self-writes there.
`timescale 1ns/1ps
module wwc_config_top (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_por_n,
  input wire logic i_lowv_programming,
  input wire logic i_wd_software_enable,
  input wire logic i_sleep,
  input wire logic i_reset_pin_enable,
  input wire logic i_scanner_disable,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [31:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output wwc_pkg::wwc_wd_out_s o_wd,
  output wwc_pkg::wwc_nvm_out_s o_nvm
);
  import wwc_pkg::*;

  localparam wwc_wd_out_s WD_SAFE = '0;
  // Safe default blocks every write until the words are known
  localparam wwc_nvm_out_s NVM_SAFE = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1,
    1'b1, 4'hf};

  // Programming-mode flag comes from the pin side
  logic lowv_meta_reg;
  logic lowv_sync_reg;
  always_ff @(posedge i_clock) begin
    lowv_meta_reg <= i_lowv_programming;
    lowv_sync_reg <= lowv_meta_reg;
  end

  // Stored words, snapshots and sequencer
  logic [15:0] wd_word_reg;
  logic [15:0] wd_word_next;
  logic [15:0] nvm_word_reg;
  logic [15:0] nvm_word_next;
  logic [15:0] wd_snap_reg;
  logic [15:0] nvm_snap_reg;
  wwc_state_e state_reg;
  wwc_state_e state_next;

  always_comb begin
    case (state_reg)
      WWC_S_HOLD: state_next = WWC_S_LOAD;
      WWC_S_LOAD: state_next = WWC_S_RUN;
      WWC_S_RUN: state_next = WWC_S_RUN;
      default: state_next = WWC_S_HOLD;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_reg <= WWC_S_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Capture only in the load state, so later word writes wait for reset
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      wd_snap_reg <= WWC_WD_RST;
      nvm_snap_reg <= WWC_NVM_RST;
    end else if (state_reg == WWC_S_LOAD) begin
      wd_snap_reg <= wd_word_reg;
      nvm_snap_reg <= nvm_word_reg;
    end
  end

  // Decoders
  wwc_wd_out_s wd_dec;
  wwc_nvm_out_s nvm_dec;

  wwc_wd_decode u_wd_decode (
    .i_cfg(wd_snap_reg),
    .i_sw_enable(i_wd_software_enable),
    .i_sleep(i_sleep),
    .o_wd(wd_dec)
  );

  wwc_nvm_decode u_nvm_decode (
    .i_cfg(nvm_snap_reg),
    .i_reset_pin_enable(i_reset_pin_enable),
    .i_scanner_disable(i_scanner_disable),
    .o_nvm(nvm_dec)
  );

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_wd <= WD_SAFE;
      o_nvm <= NVM_SAFE;
    end else if (state_reg == WWC_S_RUN) begin
      o_wd <= wd_dec;
      o_nvm <= nvm_dec;
    end
  end

  // Write channel
  logic aw_held_reg;
  logic [31:0] aw_addr_reg;
  logic w_held_reg;
  logic [15:0] w_data_reg;
  logic [1:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  wire logic aw_take = i_s_axi_awvalid & o_s_axi_awready;
  wire logic w_take = i_s_axi_wvalid & o_s_axi_wready;
  wire logic do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire logic hit_wd_w = (aw_addr_reg == WWC_ADDR_WD_CFG);
  wire logic hit_nvm_w = (aw_addr_reg == WWC_ADDR_NVM_CFG);
  wire logic hit_st_w = (aw_addr_reg == WWC_ADDR_STATUS);
  wire logic [15:0] strb_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire logic [15:0] wd_merge =
    ((wd_word_reg & ~strb_mask) | (w_data_reg & strb_mask)) & WWC_WD_MASK;
  wire logic [15:0] nvm_merge =
    ((nvm_word_reg & ~strb_mask) | (w_data_reg & strb_mask)) & WWC_NVM_MASK;
  // Dropping out of low-voltage mode mid-programming would strand the link
  wire logic lowv_refuse = hit_nvm_w & lowv_sync_reg &
    ~nvm_merge[WWC_LOWV_BIT];
  wire logic cfg_locked = o_nvm.config_wr_block;
  wire logic wr_mapped = hit_wd_w | hit_nvm_w | hit_st_w;
  wire logic wr_refused = hit_st_w | cfg_locked | lowv_refuse;
  wire logic [1:0] wr_resp = !wr_mapped ? WWC_RESP_DECERR :
    wr_refused ? WWC_RESP_SLVERR : WWC_RESP_OKAY;
  wire logic wr_commit = do_write & (wr_resp == WWC_RESP_OKAY);

  assign o_s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign o_s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= i_s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 16'h0000;
      w_strb_reg <= 2'h0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      w_data_reg <= i_s_axi_wdata[15:0];
      w_strb_reg <= i_s_axi_wstrb[1:0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= WWC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_resp;
    end else if (i_s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign wd_word_next = (wr_commit & hit_wd_w) ? wd_merge : wd_word_reg;
  assign nvm_word_next = (wr_commit & hit_nvm_w) ? nvm_merge : nvm_word_reg;

  // Words model nonvolatile cells: cleared to erased state only at power-on
  always_ff @(posedge i_clock) begin
    if (!i_por_n) begin
      wd_word_reg <= WWC_WD_RST;
      nvm_word_reg <= WWC_NVM_RST;
    end else begin
      wd_word_reg <= wd_word_next;
      nvm_word_reg <= nvm_word_next;
    end
  end

  // Read channel
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire logic ar_take = i_s_axi_arvalid & o_s_axi_arready;
  wire logic hit_wd_r = (i_s_axi_araddr == WWC_ADDR_WD_CFG);
  wire logic hit_nvm_r = (i_s_axi_araddr == WWC_ADDR_NVM_CFG);
  wire logic hit_st_r = (i_s_axi_araddr == WWC_ADDR_STATUS);
  wire logic [15:0] status_word = 16'(
    (32'(state_reg == WWC_S_RUN) << WWC_ST_LOADED) |
    (32'(o_wd.run) << WWC_ST_RUN) |
    (32'(o_wd.clk_sel) << WWC_ST_CLK_LSB) |
    (32'(lowv_sync_reg) << WWC_ST_LOWV_PROG) |
    (32'(cfg_locked) << WWC_ST_CFG_LOCK));
  wire logic [15:0] rd_word = hit_wd_r ? wd_word_reg :
    hit_nvm_r ? nvm_word_reg : hit_st_r ? status_word : 16'h0000;
  wire logic rd_mapped = hit_wd_r | hit_nvm_r | hit_st_r;

  assign o_s_axi_arready = ~rvalid_reg;
  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rdata = rdata_reg;
  assign o_s_axi_rresp = rresp_reg;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= WWC_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {16'h0000, rd_word};
      rresp_reg <= rd_mapped ? WWC_RESP_OKAY : WWC_RESP_DECERR;
    end else if (i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  wire logic run_st = (state_reg == WWC_S_RUN);
  wire logic [1:0] s_mode = wd_snap_reg[WWC_MODE_LSB +: 2];
  wire logic [2:0] s_ccs = wd_snap_reg[WWC_CCS_LSB +: 3];
  wire logic [2:0] s_cws = wd_snap_reg[WWC_CWS_LSB +: 3];
  wire logic [4:0] s_cps = wd_snap_reg[WWC_CPS_LSB +: 5];

  mode_off_clock_a: assert property (
    run_st && s_mode == 2'h0 |=> o_wd.clk_sel == WWC_CLK_NONE)
    else $error("clock chosen while watchdog disabled");

  sel_clock_a: assert property (
    run_st && s_mode != 2'h0 |=>
      (o_wd.clk_sel == WWC_CLK_SW) == ($past(s_ccs) == 3'h7) &&
      (o_wd.clk_sel == WWC_CLK_MF) == ($past(s_ccs) == 3'h1))
    else $error("clock selector decode wrong");

  reserved_clock_a: assert property (
    run_st && s_mode != 2'h0 && s_ccs inside {[3'h2:3'h6]} |=>
      o_wd.clk_sel == WWC_CLK_LF)
    else $error("reserved selector not on low oscillator");

  window_lock_a: assert property (
    run_st |=> (o_wd.window_sw_ok == ($past(s_cws) >= 3'h6)) &&
      (o_wd.keyed_required == ($past(s_cws) < 3'h6)) &&
      (o_wd.closed_eighths == (($past(s_cws) >= 3'h6) ? 3'h0 :
        3'(3'h7 - $past(s_cws)))))
    else $error("window size or lock wrong");

  mode_on_a: assert property (
    run_st && s_mode == 2'h3 |=> o_wd.run [*2])
    else $error("always-on watchdog stopped");

  mode_awake_a: assert property (
    run_st && s_mode == 2'h2 |=> o_wd.run == !$past(i_sleep))
    else $error("awake-only watchdog wrong in sleep");

  mode_sw_a: assert property (
    run_st && s_mode == 2'h1 |=> o_wd.run == $past(i_wd_software_enable))
    else $error("software enable not followed");

  mode_off_a: assert property (
    run_st && s_mode == 2'h0 |=> !o_wd.run)
    else $error("disabled watchdog running");

  period_default_a: assert property (
    run_st && s_cps == 5'h1f |=>
      o_wd.period_por == 5'h0b && o_wd.div_exp == 5'h10 &&
      o_wd.period_sw_ok)
    else $error("default period decode wrong");

  period_fixed_a: assert property (
    run_st && s_cps != 5'h1f |=> !o_wd.period_sw_ok &&
      o_wd.div_exp == (($past(s_cps) <= 5'h12) ?
        5'($past(s_cps) + 5'h05) : 5'h05))
    else $error("fixed period divider wrong");

  lowv_refuse_a: assert property (
    do_write && lowv_refuse |=> o_s_axi_bresp == WWC_RESP_SLVERR &&
      nvm_word_reg[WWC_LOWV_BIT] == $past(nvm_word_reg[WWC_LOWV_BIT]))
    else $error("low-voltage enable cleared while programming");

  reset_pin_a: assert property (
    run_st && nvm_snap_reg[WWC_LOWV_BIT] |=>
      o_nvm.reset_pin_is_reset && !o_nvm.hv_prog_required)
    else $error("shared pin not a reset in low-voltage mode");

  scanner_a: assert property (
    run_st |=> o_nvm.scanner_enabled ==
      ($past(nvm_snap_reg[WWC_SCAN_BIT]) && !$past(i_scanner_disable)))
    else $error("scanner availability wrong");

  protect_a: assert property (
    run_st |=> {o_nvm.eeprom_wr_block, o_nvm.boot_wr_block,
      o_nvm.block_wr_block} == ~{$past(nvm_snap_reg[WWC_EEP_BIT]),
      $past(nvm_snap_reg[WWC_BOOT_BIT]), $past(nvm_snap_reg[3:0])})
    else $error("write protection outputs wrong");

  cfg_lock_a: assert property (
    do_write && cfg_locked |=> o_s_axi_bvalid &&
      $stable(wd_word_reg) && $stable(nvm_word_reg))
    else $error("locked configuration word changed");

  snap_load_a: assert property (
    state_reg == WWC_S_LOAD |=> run_st && wd_snap_reg ==
      $past(wd_word_reg) && nvm_snap_reg == $past(nvm_word_reg))
    else $error("snapshot not taken at release");

  snap_hold_a: assert property (
    run_st |=> $stable(wd_snap_reg) && $stable(nvm_snap_reg))
    else $error("snapshot changed after load");
endmodule : wwc_config_top

// ==== tb/wwc_far_model.sv ====
// Purpose: Core-side control bits that sit beside the watchdog
// Assumes: Sleep and software enable change only on the system clock
// Notes: Registered, so a request shows one cycle after it is made
`timescale 1ns/1ps
module wwc_far_model (
  input wire logic i_clock,
  input wire logic i_sleep_req,
  input wire logic i_swen_req,
  output logic o_sleep = 1'b0,
  output logic o_sw_enable = 1'b0
);
  // Levels come from core registers, never from an asynchronous source
  always @(posedge i_clock) begin
    o_sleep <= i_sleep_req;
    o_sw_enable <= i_swen_req;
  end
endmodule : wwc_far_model

// ==== tb/wwc_tb.sv ====
// Purpose: Bus-level bench for the configuration word decoder
// Assumes: Outputs settle within four cycles of any input or reset change
// Notes: Config lock test comes last, since it freezes both words
`timescale 1ns/1ps
module testbench;
  import wwc_pkg::*;
  logic clk = 0, rst_n = 0, por_n = 0, lowvp = 0, sl_req = 0, en_req = 0;
  logic rpe = 0, sdis = 0, sleep, swen;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [15:0] prev;
  wwc_wd_out_s wd;
  wwc_nvm_out_s nvm;
  wwc_wd_out_s xw;
  wwc_nvm_out_s xn;
  int n_fail = 0, n_compared = 0;
  logic [15:0] wtab [7] = '{16'h0d00, 16'h0852, 16'h1c33, 16'h367e,
    16'h034b, 16'h113f, 16'h3a01};
  logic [15:0] ntab [3] = '{16'h230a, 16'h1505, 16'h3600};

  wwc_config_top u_dut (.i_clock(clk), .i_reset_n(rst_n), .i_por_n(por_n),
    .i_lowv_programming(lowvp), .i_wd_software_enable(swen),
    .i_sleep(sleep), .i_reset_pin_enable(rpe), .i_scanner_disable(sdis),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_wd(wd), .o_nvm(nvm));
  wwc_far_model u_far (.i_clock(clk), .i_sleep_req(sl_req),
    .i_swen_req(en_req), .o_sleep(sleep), .o_sw_enable(swen));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [15:0] d,
    input logic [1:0] er);
    logic pa, pw, fa, fw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      fa = pa && (awready === 1'b1);
      fw = pw && (wready === 1'b1);
      @(posedge clk);
      if (fa) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (fw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp,
    input logic [31:0] mask, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    chk(rdata & mask, exp);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge clk);
    rready <= 1'b0;
  endtask : rdchk

  task automatic rst_pulse;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : rst_pulse

  function automatic wwc_wd_out_s exp_wd(input logic [15:0] w,
    input logic sl, input logic en);
    wwc_wd_out_s e;
    logic [2:0] cs, ws;
    logic [1:0] m;
    logic [4:0] ps;
    cs = w[13:11];
    ws = w[10:8];
    m = w[6:5];
    ps = w[4:0];
    e.run = (m == 2'h3) || (m == 2'h2 && !sl) || (m == 2'h1 && en);
    e.clk_sel = (m == 2'h0) ? WWC_CLK_NONE : (cs == 3'h7) ? WWC_CLK_SW :
      (cs == 3'h1) ? WWC_CLK_MF : WWC_CLK_LF;
    e.window_por = ws;
    e.closed_eighths = (ws >= 3'h6) ? 3'h0 : 3'h7 - ws;
    e.window_sw_ok = ws >= 3'h6;
    e.keyed_required = ws < 3'h6;
    e.period_por = (ps == 5'h1f) ? 5'h0b : ps;
    e.div_exp = (ps == 5'h1f) ? 5'h10 : (ps <= 5'h12) ? ps + 5'h05 : 5'h05;
    e.period_sw_ok = ps == 5'h1f;
    return e;
  endfunction : exp_wd

  function automatic wwc_nvm_out_s exp_nvm(input logic [15:0] w,
    input logic rp, input logic sd);
    wwc_nvm_out_s e;
    e.reset_pin_is_reset = w[13] | rp;
    e.hv_prog_required = !w[13];
    e.scanner_enabled = w[12] & !sd;
    e.eeprom_wr_block = !w[10];
    e.boot_wr_block = !w[9];
    e.config_wr_block = !w[8];
    e.block_wr_block = ~w[3:0];
    return e;
  endfunction : exp_nvm

  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(WWC_ADDR_WD_CFG, 32'h3f7f, 32'hffffffff, WWC_RESP_OKAY);
    rdchk(WWC_ADDR_NVM_CFG, 32'h370f, 32'hffffffff, WWC_RESP_OKAY);
    rdchk(WWC_ADDR_STATUS, 32'hf, 32'hffffffff, WWC_RESP_OKAY);
    rdchk(32'h4, 32'h0, 32'hffffffff, WWC_RESP_DECERR);
    wr(WWC_ADDR_STATUS, 16'h0001, WWC_RESP_SLVERR);
    wr(32'h8, 16'h0001, WWC_RESP_DECERR);
    $display("test bus_map done");
    prev = 16'h3f7f;
    foreach (wtab[i]) begin
      wr(WWC_ADDR_WD_CFG, wtab[i], WWC_RESP_OKAY);
      @(negedge clk);
      chk(32'(wd), 32'(exp_wd(prev, sl_req, en_req)));
      rst_pulse();
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        sl_req <= k[1];
        en_req <= k[0];
        repeat (4) @(posedge clk);
        @(negedge clk);
        xw = exp_wd(wtab[i], k[1], k[0]);
        chk(32'(wd.run), 32'(xw.run));
        chk(32'(wd.clk_sel), 32'(xw.clk_sel));
        chk(32'(wd[18:0]), 32'(xw[18:0]));
      end
      rdchk(WWC_ADDR_WD_CFG, {16'h0, wtab[i] & 16'h3f7f}, 32'hffffffff,
        WWC_RESP_OKAY);
      prev = wtab[i];
    end
    $display("test watchdog_decode done");
    @(posedge clk);
    lowvp <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(WWC_ADDR_STATUS, 32'h11, 32'hffffffff, WWC_RESP_OKAY);
    wr(WWC_ADDR_NVM_CFG, 16'h170f, WWC_RESP_SLVERR);
    rdchk(WWC_ADDR_NVM_CFG, 32'h370f, 32'hffffffff, WWC_RESP_OKAY);
    wr(WWC_ADDR_NVM_CFG, 16'h370e, WWC_RESP_OKAY);
    rdchk(WWC_ADDR_NVM_CFG, 32'h370e, 32'hffffffff, WWC_RESP_OKAY);
    lowvp <= 1'b0;
    $display("test lowv_guard done");
    foreach (ntab[i]) begin
      wr(WWC_ADDR_NVM_CFG, ntab[i], WWC_RESP_OKAY);
      rst_pulse();
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        rpe <= k[1];
        sdis <= k[0];
        repeat (4) @(posedge clk);
        @(negedge clk);
        xn = exp_nvm(ntab[i], k[1], k[0]);
        chk(32'(nvm[9:7]), 32'(xn[9:7]));
        chk(32'(nvm[6:0]), 32'(xn[6:0]));
      end
    end
    wr(WWC_ADDR_NVM_CFG, 16'h370f, WWC_RESP_SLVERR);
    wr(WWC_ADDR_WD_CFG, 16'h3f7f, WWC_RESP_SLVERR);
    rdchk(WWC_ADDR_NVM_CFG, 32'h3600, 32'hffffffff, WWC_RESP_OKAY);
    rdchk(WWC_ADDR_STATUS, 32'h21, 32'hffffffff, WWC_RESP_OKAY);
    $display("test write_protect done");
    report_and_stop();
  end
endmodule : testbench
